// file: rtl/cai_top.sv
// Command control and interrupt enable registers with APB access and IRQ pin drive
//
// Overview of operation
// - Offset zero reserved, reads zero, resets zero
// - Command control at one, resets to 20h
// - Receiver-off bit powers down analog receiver
// - Writing power-down one enters low power
// - Power-down zero wakes; reads one until ready
// - Power-down ignored while reinit command runs
// - Command write launches; read shows running command
// - Common enable at two, resets to 80h
// - Polarity bit one inverts IRQ pin
// - Polarity zero follows; reset open-drain floats
// - Bits six, five gate tx, rx
// - Bits four, three gate idle, high
// - Bits two to zero gate low, error, timer
// - Secondary enable at three, resets zero
// - Drive bit selects push-pull or open-drain
// - Bit four gates card input edge request
// - Bit two gates checksum done request
// - Common request flags match enable positions
// - Bit seven selects set or clear of marked
// - Checksum done flag raised when data processed
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module cai_top #(
  parameter int unsigned WAKE_CYCLES      = cai_pkg::WAKE_CYCLES,
  parameter logic [3:0]  REINIT_CODE      = 4'hf,
  parameter logic [3:0]  CHECKSUM_CODE    = 4'h3,
  parameter logic [15:0] VALID_CMD_MASK   = 16'hffff
) (
  // Clock and reset
  input  wire logic                I_MCLK,
  input  wire logic                I_SRST,
  // APB slave
  input  wire logic                I_PSEL,
  input  wire logic                I_PENABLE,
  input  wire logic                I_PWRITE,
  input  wire logic [7:0]          I_PADDR,
  input  wire logic [31:0]         I_PWDATA,
  output logic      [31:0]         O_PRDATA,
  output logic                     O_PREADY,
  output logic                     O_PSLVERR,
  // Command engine
  input  wire cai_pkg::cai_events_t I_EVENTS,
  input  wire logic                I_CMD_DONE,
  input  wire logic                I_CHECKSUM_DATA_DONE,
  output logic      [3:0]          O_CMD_CODE,
  output logic                     O_CMD_START,
  // Analog and power control
  output logic                     O_RECEIVER_OFF,
  output logic                     O_LOW_POWER,
  output logic                     O_WAKE_BUSY,
  // Card interface pin
  input  wire logic                I_CARD_INTERFACE_INPUT,
  // IRQ pin
  output logic                     O_IRQ_OUT,
  output logic                     O_IRQ_OE_N
);

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic       access_done;
  logic       wr_en;
  logic       mapped;
  logic [5:0] idx;
  logic [7:0] wbyte;
  logic       pready_r;
  logic       pready_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic       pslverr_r;
  logic       pslverr_nxt;
  logic [7:0] rd_byte;

  // One wait state: pready rises in the second access cycle
  assign idx         = I_PADDR[7:2];
  assign wbyte       = I_PWDATA[7:0];
  assign mapped      = (I_PADDR[1:0] == 2'h0) && (idx <= cai_pkg::IDX_SECONDARY_IRQ_REQUEST);
  assign access_done = I_PSEL && I_PENABLE && pready_r;
  assign wr_en       = access_done && I_PWRITE && mapped;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic             rcv_off_r,  rcv_off_nxt;
  logic [3:0]       cmd_r,      cmd_nxt;
  logic             start_r,    start_nxt;
  logic [7:0]       com_en_r,   com_en_nxt;
  logic [7:0]       sec_en_r,   sec_en_nxt;
  logic [7:0]       com_req_r,  com_req_nxt;
  logic [7:0]       sec_req_r,  sec_req_nxt;
  cai_pkg::cai_pwr_t pwr_r,     pwr_nxt;
  logic [15:0]      wake_cnt_r, wake_cnt_nxt;
  logic             pd_bit;
  logic [7:0]       cmd_ctl_rd;
  logic             wr_cmd;
  logic             cmd_stop_flag;
  logic             unknown_cmd;
  logic [7:0]       com_hw_set;
  logic [7:0]       sec_hw_set;
  logic             card_edge;

  // Card input: two flops to synchronise, a third to find edges
  logic card_meta_r, card_sync_r, card_prev_r;
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      card_meta_r <= 1'b0;
      card_sync_r <= 1'b0;
      card_prev_r <= 1'b0;
    end else begin
      card_meta_r <= I_CARD_INTERFACE_INPUT;
      card_sync_r <= card_meta_r;
      card_prev_r <= card_sync_r;
    end
  end
  assign card_edge = card_sync_r ^ card_prev_r;

  // Power-down bit reads one while down or waking
  assign pd_bit     = (pwr_r != cai_pkg::PWR_ACTIVE);
  assign cmd_ctl_rd = {2'b00, rcv_off_r, pd_bit, cmd_r};
  assign wr_cmd     = wr_en && (idx == cai_pkg::IDX_COMMAND_CONTROL);
  assign unknown_cmd = wr_cmd && !VALID_CMD_MASK[wbyte[3:0]];
  // A command ending by itself or refused as unknown counts as finished
  assign cmd_stop_flag = (I_CMD_DONE && (cmd_r != cai_pkg::CMD_IDLE)) || unknown_cmd;

  // Hardware request sources, placed at their enable positions
  assign com_hw_set = {1'b0, I_EVENTS.tx_done, I_EVENTS.rx_done,
                       I_EVENTS.cmd_finished | cmd_stop_flag, I_EVENTS.fifo_high,
                       I_EVENTS.fifo_low, I_EVENTS.error, I_EVENTS.timer_expiry};
  assign sec_hw_set = {3'b000, card_edge, 1'b0,
                       (cmd_r == CHECKSUM_CODE) && I_CHECKSUM_DATA_DONE, 2'b00};

  // Next state of control, power and enable registers
  always_comb begin
    rcv_off_nxt  = rcv_off_r;
    cmd_nxt      = cmd_r;
    start_nxt    = 1'b0;
    com_en_nxt   = com_en_r;
    sec_en_nxt   = sec_en_r;
    pwr_nxt      = pwr_r;
    wake_cnt_nxt = wake_cnt_r;
    if (wr_cmd) begin
      rcv_off_nxt = wbyte[cai_pkg::BIT_RECEIVER_OFF];
      if (unknown_cmd) begin
        cmd_nxt = cai_pkg::CMD_IDLE;
      end else begin
        cmd_nxt   = wbyte[cai_pkg::CMD_LSB +: cai_pkg::CMD_W];
        start_nxt = (wbyte[cai_pkg::CMD_LSB +: cai_pkg::CMD_W] != cai_pkg::CMD_IDLE);
      end
    end else if (I_CMD_DONE) begin
      cmd_nxt = cai_pkg::CMD_IDLE;
    end
    // Power sequence
    unique case (pwr_r)
      cai_pkg::PWR_ACTIVE: begin
        // Reinit blocks entry so that a reset in flight completes
        if (wr_cmd && wbyte[cai_pkg::BIT_LOW_POWER_REQUEST] && (cmd_r != REINIT_CODE)) begin
          pwr_nxt = cai_pkg::PWR_DOWN;
        end
      end
      cai_pkg::PWR_DOWN: begin
        if (wr_cmd && !wbyte[cai_pkg::BIT_LOW_POWER_REQUEST]) begin
          pwr_nxt      = cai_pkg::PWR_WAKE;
          wake_cnt_nxt = 16'(WAKE_CYCLES);
        end
      end
      cai_pkg::PWR_WAKE: begin
        if (wake_cnt_r <= 16'h0001) begin
          pwr_nxt      = cai_pkg::PWR_ACTIVE;
          wake_cnt_nxt = 16'h0000;
        end else begin
          wake_cnt_nxt = wake_cnt_r - 16'h0001;
        end
      end
      default: begin
        pwr_nxt = cai_pkg::PWR_ACTIVE;
      end
    endcase
    if (wr_en && (idx == cai_pkg::IDX_COMMON_IRQ_ENABLE)) begin
      com_en_nxt = wbyte;
    end
    if (wr_en && (idx == cai_pkg::IDX_SECONDARY_IRQ_ENABLE)) begin
      sec_en_nxt = wbyte & cai_pkg::SECONDARY_ENABLE_MASK;
    end
  end

  // Request flags: software set/clear, hardware set wins over a clear
  always_comb begin
    logic [7:0] sw_set;
    logic [7:0] sw_clr;
    sw_set = 8'h00;
    sw_clr = 8'h00;
    if (wr_en && (idx == cai_pkg::IDX_COMMON_IRQ_REQUEST)) begin
      if (wbyte[cai_pkg::BIT_SET_CLEAR_SELECT]) begin
        sw_set = wbyte;
      end else begin
        sw_clr = wbyte;
      end
    end
    com_req_nxt = ((com_req_r & ~sw_clr) | sw_set | com_hw_set) & cai_pkg::COMMON_FLAG_MASK;
    sw_set = 8'h00;
    sw_clr = 8'h00;
    if (wr_en && (idx == cai_pkg::IDX_SECONDARY_IRQ_REQUEST)) begin
      if (wbyte[cai_pkg::BIT_SET_CLEAR_SELECT]) begin
        sw_set = wbyte;
      end else begin
        sw_clr = wbyte;
      end
    end
    sec_req_nxt = ((sec_req_r & ~sw_clr) | sw_set | sec_hw_set) & cai_pkg::SECONDARY_FLAG_MASK;
  end

  // Register the control and request state
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      rcv_off_r  <= cai_pkg::RST_COMMAND_CONTROL[cai_pkg::BIT_RECEIVER_OFF];
      cmd_r      <= cai_pkg::RST_COMMAND_CONTROL[3:0];
      start_r    <= 1'b0;
      com_en_r   <= cai_pkg::RST_COMMON_IRQ_ENABLE;
      sec_en_r   <= cai_pkg::RST_SECONDARY_IRQ_ENABLE;
      com_req_r  <= cai_pkg::RST_COMMON_IRQ_REQUEST;
      sec_req_r  <= cai_pkg::RST_SECONDARY_IRQ_REQUEST;
      pwr_r      <= cai_pkg::PWR_ACTIVE;
      wake_cnt_r <= 16'h0000;
    end else begin
      rcv_off_r  <= rcv_off_nxt;
      cmd_r      <= cmd_nxt;
      start_r    <= start_nxt;
      com_en_r   <= com_en_nxt;
      sec_en_r   <= sec_en_nxt;
      com_req_r  <= com_req_nxt;
      sec_req_r  <= sec_req_nxt;
      pwr_r      <= pwr_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  // ****************************************************************
  // APB read path
  // ****************************************************************

  // Read mux; reserved slot and reserved bits read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      cai_pkg::IDX_RESERVED_SLOT_ZERO:    rd_byte = cai_pkg::RST_RESERVED_SLOT_ZERO;
      cai_pkg::IDX_COMMAND_CONTROL:       rd_byte = cmd_ctl_rd;
      cai_pkg::IDX_COMMON_IRQ_ENABLE:     rd_byte = com_en_r;
      cai_pkg::IDX_SECONDARY_IRQ_ENABLE:  rd_byte = sec_en_r;
      cai_pkg::IDX_COMMON_IRQ_REQUEST:    rd_byte = com_req_r;
      cai_pkg::IDX_SECONDARY_IRQ_REQUEST: rd_byte = sec_req_r;
      default:                            rd_byte = 8'h00;
    endcase
    if (!mapped) begin
      rd_byte = 8'h00;
    end
  end

  // Answer is loaded the cycle before completion so it is a flop output
  always_comb begin
    pready_nxt  = I_PSEL && I_PENABLE && !pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (pready_nxt) begin
      prdata_nxt  = {24'h000000, rd_byte};
      pslverr_nxt = !mapped;
    end
  end

  // Register the bus answer
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ****************************************************************
  // IRQ pin
  // ****************************************************************
  logic irq_any;
  logic irq_level;
  logic irq_out_r, irq_out_nxt;
  logic irq_oe_n_r, irq_oe_n_nxt;

  // Combined status; flag and enable positions coincide
  assign irq_any   = |(com_req_r & com_en_r & cai_pkg::COMMON_FLAG_MASK)
                   | |(sec_req_r & sec_en_r & cai_pkg::SECONDARY_FLAG_MASK);
  assign irq_level = irq_any ^ com_en_r[cai_pkg::BIT_POLARITY_INVERT];

  // Open drain only pulls low; a high level releases the pin
  always_comb begin
    irq_out_nxt  = irq_level;
    irq_oe_n_nxt = 1'b0;
    if (!sec_en_r[cai_pkg::BIT_DRIVE_TYPE] && irq_level) begin
      irq_oe_n_nxt = 1'b1;
    end
  end

  // Register the pin drive
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      irq_out_r  <= 1'b1;
      irq_oe_n_r <= 1'b1;
    end else begin
      irq_out_r  <= irq_out_nxt;
      irq_oe_n_r <= irq_oe_n_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_PRDATA       = prdata_r;
  assign O_PREADY       = pready_r;
  assign O_PSLVERR      = pslverr_r;
  assign O_CMD_CODE     = cmd_r;
  assign O_CMD_START    = start_r;
  assign O_RECEIVER_OFF = rcv_off_r;
  assign O_LOW_POWER    = (pwr_r == cai_pkg::PWR_DOWN);
  assign O_WAKE_BUSY    = (pwr_r == cai_pkg::PWR_WAKE);
  assign O_IRQ_OUT      = irq_out_r;
  assign O_IRQ_OE_N     = irq_oe_n_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int WakeBound = 300;

  a_rsvd_slot_zero: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (access_done && !I_PWRITE && (I_PADDR == 8'h00)) |-> (O_PRDATA == 32'h00000000))
    else $error("reserved slot read not zero");

  a_pd_wake_seq: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (O_LOW_POWER && wr_cmd && !wbyte[cai_pkg::BIT_LOW_POWER_REQUEST])
      |=> (pd_bit && O_WAKE_BUSY) ##[1:WakeBound] (!pd_bit && !O_WAKE_BUSY))
    else $error("wake sequence wrong");

  a_pd_reinit_block: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (pwr_r == cai_pkg::PWR_ACTIVE && wr_cmd && cmd_r == REINIT_CODE) |=> !O_LOW_POWER)
    else $error("low power entered during reinit");

  a_pd_enter: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (pwr_r == cai_pkg::PWR_ACTIVE && wr_cmd && wbyte[cai_pkg::BIT_LOW_POWER_REQUEST]
      && cmd_r != REINIT_CODE) |=> O_LOW_POWER ##1 pd_bit)
    else $error("low power not entered");

  a_cmd_launch: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (wr_cmd && !unknown_cmd && wbyte[3:0] != cai_pkg::CMD_IDLE)
      |=> (O_CMD_START && O_CMD_CODE == $past(wbyte[3:0])) ##1 !O_CMD_START)
    else $error("command not launched");

  a_irq_polarity: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    ##1 (O_IRQ_OUT == ($past(irq_any) ^ $past(com_en_r[cai_pkg::BIT_POLARITY_INVERT]))))
    else $error("irq pin polarity wrong");

  a_irq_open_drain: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (!sec_en_r[cai_pkg::BIT_DRIVE_TYPE] && irq_level) |=> O_IRQ_OE_N)
    else $error("open drain pin driven high");

  a_req_set_wins: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (I_EVENTS.tx_done && wr_en && idx == cai_pkg::IDX_COMMON_IRQ_REQUEST)
      |=> com_req_r[cai_pkg::BIT_TX_DONE])
    else $error("event lost to clear");

  a_checksum_flag: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    ((cmd_r == CHECKSUM_CODE) && I_CHECKSUM_DATA_DONE) |=> sec_req_r[cai_pkg::BIT_CHECKSUM_DONE])
    else $error("checksum flag not raised");

  c_wake_done: cover property (@(posedge I_MCLK) disable iff (I_SRST)
    O_WAKE_BUSY ##1 !O_WAKE_BUSY);

  c_irq_push_pull: cover property (@(posedge I_MCLK) disable iff (I_SRST)
    sec_en_r[cai_pkg::BIT_DRIVE_TYPE] && !O_IRQ_OE_N && O_IRQ_OUT);

  c_unmapped: cover property (@(posedge I_MCLK) disable iff (I_SRST)
    O_PREADY && O_PSLVERR);

endmodule

// file: pkg/cai_pkg.sv
// Package: register map, field layout, reset values and timing for the command and IRQ enable block
package cai_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_RESERVED_SLOT_ZERO   = 6'h00;
  localparam logic [5:0] IDX_COMMAND_CONTROL      = 6'h01;
  localparam logic [5:0] IDX_COMMON_IRQ_ENABLE    = 6'h02;
  localparam logic [5:0] IDX_SECONDARY_IRQ_ENABLE = 6'h03;
  localparam logic [5:0] IDX_COMMON_IRQ_REQUEST   = 6'h04;
  localparam logic [5:0] IDX_SECONDARY_IRQ_REQUEST = 6'h05;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_RESERVED_SLOT_ZERO   = 8'h00;
  localparam logic [7:0] RST_COMMAND_CONTROL      = 8'h20;
  localparam logic [7:0] RST_COMMON_IRQ_ENABLE    = 8'h80;
  localparam logic [7:0] RST_SECONDARY_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_COMMON_IRQ_REQUEST   = 8'h14;
  localparam logic [7:0] RST_SECONDARY_IRQ_REQUEST = 8'h00;

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int unsigned BIT_RECEIVER_OFF      = 5;
  localparam int unsigned BIT_LOW_POWER_REQUEST = 4;
  localparam int unsigned CMD_LSB               = 0;
  localparam int unsigned CMD_W                 = 4;
  localparam int unsigned BIT_POLARITY_INVERT   = 7;
  localparam int unsigned BIT_DRIVE_TYPE        = 7;
  localparam int unsigned BIT_SET_CLEAR_SELECT  = 7;
  localparam int unsigned BIT_CARD_INPUT_EDGE   = 4;
  localparam int unsigned BIT_CHECKSUM_DONE     = 2;
  localparam int unsigned BIT_TX_DONE           = 6;
  localparam logic [7:0] COMMON_FLAG_MASK       = 8'h7f;
  localparam logic [7:0] SECONDARY_FLAG_MASK    = 8'h14;
  localparam logic [7:0] SECONDARY_ENABLE_MASK  = 8'h94;

  // ****************************************************************
  // Command codes and timing
  // ****************************************************************
  localparam logic [3:0] CMD_IDLE            = 4'h0;
  localparam int unsigned CLK_PERIOD_NS      = 8;
  localparam int unsigned WAKE_TIME_NS       = 1024;
  localparam int unsigned WAKE_CYCLES        = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power management states
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_DOWN   = 3'b010,
    PWR_WAKE   = 3'b100
  } cai_pwr_t;

  // Request events raised by the command engine, one pulse each
  typedef struct packed {
    logic tx_done;
    logic rx_done;
    logic cmd_finished;
    logic fifo_high;
    logic fifo_low;
    logic error;
    logic timer_expiry;
  } cai_events_t;

endpackage

// file: verification/cai_irq_host.sv
// Host side of the IRQ pin: resolves the open-drain or push-pull pin level
`timescale 1ns/1ps
module cai_irq_host (
  // Pin from the device
  input  wire logic i_irq_out,
  input  wire logic i_irq_oe_n,
  // Level seen by the host
  output logic      o_pin_level
);
  // Board pull-up holds the line high whenever the device lets go of it
  assign o_pin_level = i_irq_oe_n ? 1'b1 : i_irq_out;
endmodule

// file: verification/cai_top_tb_top.sv
// Testbench: APB register access and IRQ pin checks for the command and IRQ enable block
`timescale 1ns/1ps
module cai_top_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                 clk;
  logic                 srst;
  logic                 psel, penable, pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready, pslverr;
  cai_pkg::cai_events_t ev;
  logic                 cmd_done, crc_done, card_in;
  logic [3:0]           cmd_code;
  logic                 cmd_start, rcv_off, low_pwr, wake_busy, irq_out, irq_oe_n, pin;
  int                   miscompares;
  int                   tests_run;
  logic [7:0]           rd;
  logic                 err;

  // Short wake time keeps the run brief
  cai_top #(.WAKE_CYCLES(16)) i_dut (
    .I_MCLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_EVENTS(ev), .I_CMD_DONE(cmd_done), .I_CHECKSUM_DATA_DONE(crc_done), .O_CMD_CODE(cmd_code),
    .O_CMD_START(cmd_start), .O_RECEIVER_OFF(rcv_off), .O_LOW_POWER(low_pwr), .O_WAKE_BUSY(wake_busy),
    .I_CARD_INTERFACE_INPUT(card_in), .O_IRQ_OUT(irq_out), .O_IRQ_OE_N(irq_oe_n));

  cai_irq_host i_host (.i_irq_out(irq_out), .i_irq_oe_n(irq_oe_n), .o_pin_level(pin));

  // ****************************************************************
  // Clock, reset and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Whole sequence needs about 350 cycles; generous margin before giving up
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d}; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) miscompares++;
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  // Let a register write or a flag reach the registered pin
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pulse_ev(input logic [6:0] v);
    @(posedge clk) ev <= cai_pkg::cai_events_t'(v);
    @(posedge clk) ev <= '0;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    miscompares = 0; tests_run = 0;
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    ev = '0; cmd_done = 1'b0; crc_done = 1'b0; card_in = 1'b0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    settle();
    // Reset values and floating pin
    chk(irq_oe_n, 8'h01);
    chk(pin, 8'h01);
    chk(rcv_off, 8'h01);
    rdc(8'h00, 8'h00);
    rdc(8'h04, 8'h20);
    rdc(8'h08, 8'h80);
    rdc(8'h0c, 8'h00);
    rdc(8'h10, 8'h14);
    // Reserved places and an unmapped address
    wr(8'h00, 8'hff);
    rdc(8'h00, 8'h00);
    wr(8'h0c, 8'hff);
    rdc(8'h0c, 8'h94);
    rdc(8'h18, 8'h00);
    chk(err, 8'h01);
    // Open drain, polarity straight, nothing pending: pin driven low
    wr(8'h0c, 8'h00);
    wr(8'h10, 8'h7f);
    wr(8'h08, 8'h00);
    settle();
    chk({irq_oe_n, pin}, 8'h00);
    // Each common request through its own enable, push-pull drive
    wr(8'h0c, 8'h80);
    for (int i = 0; i < 7; i++) begin
      wr(8'h10, 8'h7f);
      wr(8'h08, 8'h01 << i);
      pulse_ev(7'h01 << i);
      settle();
      chk({irq_oe_n, irq_out}, 8'h01);
      rdc(8'h10, 8'h01 << i);
    end
    // Masked request leaves the pin low
    wr(8'h08, 8'h00);
    settle();
    chk(irq_out, 8'h00);
    // Software set and clear through bit seven
    wr(8'h10, 8'h7f);
    wr(8'h10, 8'h81);
    rdc(8'h10, 8'h01);
    wr(8'h08, 8'h81);
    settle();
    chk(irq_out, 8'h00);
    wr(8'h10, 8'h01);
    rdc(8'h10, 8'h00);
    settle();
    chk(irq_out, 8'h01);
    // Event in the same cycle as a clear write keeps its flag
    fork
      wr(8'h10, 8'h7f);
      begin
        repeat (3) @(posedge clk);
        ev <= cai_pkg::cai_events_t'(7'h40);
        @(posedge clk);
        ev <= '0;
      end
    join
    rdc(8'h10, 8'h40);
    // Checksum command: launch, read back, completion flag
    wr(8'h14, 8'h7f);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h03);
    #1;
    chk(cmd_code, 8'h03);
    chk(cmd_start, 8'h01);
    chk(rcv_off, 8'h00);
    rdc(8'h04, 8'h03);
    @(posedge clk) crc_done <= 1'b1;
    @(posedge clk) crc_done <= 1'b0;
    rdc(8'h14, 8'h04);
    wr(8'h0c, 8'h84);
    settle();
    chk(irq_out, 8'h01);
    // Command end returns to idle and raises the idle flag
    wr(8'h10, 8'h7f);
    @(posedge clk) cmd_done <= 1'b1;
    @(posedge clk) cmd_done <= 1'b0;
    rdc(8'h04, 8'h00);
    rdc(8'h10, 8'h10);
    // Card input edge flag and its enable
    wr(8'h14, 8'h7f);
    wr(8'h0c, 8'h80);
    @(posedge clk) card_in <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(8'h14, 8'h10);
    wr(8'h0c, 8'h90);
    settle();
    chk(irq_out, 8'h01);
    // Low power entry, then wake-up reading one until ready
    wr(8'h04, 8'h10);
    #1;
    chk(low_pwr, 8'h01);
    rdc(8'h04, 8'h10);
    wr(8'h04, 8'h00);
    #1;
    chk(wake_busy, 8'h01);
    rdc(8'h04, 8'h10);
    repeat (30) @(posedge clk);
    rdc(8'h04, 8'h00);
    chk(low_pwr, 8'h00);
    // Low power refused while the reinit command runs
    wr(8'h04, 8'h0f);
    wr(8'h04, 8'h1f);
    settle();
    chk(low_pwr, 8'h00);
    complete_run();
  end
endmodule
